// >>> logic/isc_params.svh
// Purpose: constants of the interrupt and standby controller
// Assumes: 4-bit register data, 16-bit register addresses, clk at 125 MHz
// Notes:   offsets, field positions, reset values and timing counts
`ifndef ISC_PARAMS_SVH
`define ISC_PARAMS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define ISC_OFS_PTIMER_FLAGS 16'hFFF2
`define ISC_OFS_SERIAL_FLAGS 16'hFFF3
`define ISC_OFS_CLKTMR_FLAGS 16'hFFF6
`define ISC_OFS_STOPW_FLAGS  16'hFFF7
`define ISC_OFS_PORT_FLAGS   16'hFFFB
`define ISC_OFS_PTIMER_MASK  16'hFFE2
`define ISC_OFS_SERIAL_MASK  16'hFFE3
`define ISC_OFS_CLKTMR_MASK  16'hFFE6
`define ISC_OFS_STOPW_MASK   16'hFFE7
`define ISC_OFS_PORT_MASK    16'hFFEB

// ----------------------------------------------------------------------------
// implemented bits per group and reset values
// ----------------------------------------------------------------------------
`define ISC_BITS_PTIMER 4'h3
`define ISC_BITS_SERIAL 4'h7
`define ISC_BITS_CLKTMR 4'hF
`define ISC_BITS_STOPW  4'h3
`define ISC_BITS_PORT   4'hF
`define ISC_FLAG_RESET  4'h0
`define ISC_MASK_RESET  4'h0

// ----------------------------------------------------------------------------
// vectors and timing
// ----------------------------------------------------------------------------
`define ISC_VEC_BASE      16'h0100
`define ISC_VEC_STEP      16'h0002
`define ISC_SETTLE_TIME_US 5000
`define ISC_CLK_MHZ       125

`endif

// >>> logic/isc_pkg.sv
// Purpose: types shared by the interrupt and standby controller
// Assumes: constants live in isc_params.svh
// Notes:   group index order follows the vector priority
package isc_pkg;

	// ------------------------------------------------------------------------
	// event inputs from peripherals, all on clk
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] ptimerZero;  // 1: timer 1, 0: timer 0 reached zero (pulse)
		logic [2:0] serialEv;    // 2: rx error, 1: tx done, 0: rx done (pulse)
		logic [3:0] portLineEv;  // selected edge seen on input_port_lines (pulse)
		logic [3:0] clkTmrLvl;   // 3: 1 Hz, 2: 2 Hz, 1: 8 Hz, 0: 32 Hz levels
		logic [1:0] stopwEv;     // 1: 1 Hz, 0: 10 Hz (pulse)
	} isc_events_t;

	// ------------------------------------------------------------------------
	// strobes from the cpu core
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic irqAck;      // interrupt accepted
		logic eiSet;       // enable_irqs_state instruction
		logic diSet;       // disable_irqs_state instruction
		logic retiExec;    // return_from_irq instruction
		logic haltExec;    // halt instruction
		logic sleepExec;   // sleep_instruction
		logic sp1Write;    // first_stack_pointer written
		logic sp2Write;    // second_stack_pointer written
	} isc_cpu_cmd_t;

	typedef enum logic [1:0] {
		ISC_RUN    = 2'b00,
		ISC_SLEEP  = 2'b01,
		ISC_SETTLE = 2'b11,
		ISC_HALT   = 2'b10
	} isc_state_t;

endpackage : isc_pkg

// >>> logic/isc_osc_settle.sv
// Purpose: oscillation settling wait after sleep
// Assumes: start is a one-cycle pulse
// Notes:   done pulses SETTLE_CYCLES cycles after start
`timescale 1ns/1ps
module isc_osc_settle
	import isc_pkg::*;
#(
	parameter int SETTLE_CYCLES = 625000
) (
	input  wire logic clk,    // system clock
	input  wire logic rst,    // synchronous reset, high
	input  wire logic start,  // begin waiting
	output logic      done    // wait over, one cycle
);
	localparam int CW = $clog2(SETTLE_CYCLES + 1);

	logic [CW-1:0] count_ff;
	logic          busy_ff;

	// ------------------------------------------------------------------------
	// down counter
	// ------------------------------------------------------------------------
	// a restart while busy reloads, so the full wait always follows a start
	always_ff @(posedge clk) begin
		if (rst) begin
			count_ff <= '0;
			busy_ff  <= 1'b0;
			done     <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				count_ff <= CW'(SETTLE_CYCLES - 1);
				busy_ff  <= 1'b1;
			end else if (busy_ff) begin
				if (count_ff == '0) begin
					busy_ff <= 1'b0;
					done    <= 1'b1;
				end else begin
					count_ff <= count_ff - 1'b1;
				end
			end
		end
	end

endmodule : isc_osc_settle

// >>> logic/isc_ctrl.sv
// Purpose: interrupt flags, masks, request gating and halt/sleep control
// Assumes: events and cpu strobes are on clk; edge logic of port lines is outside
// Notes:   request outputs are levels; the cpu vectors on irqAck
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "isc_params.svh"
module isc_ctrl
	import isc_pkg::*;
#(
	parameter int SETTLE_CYCLES = `ISC_SETTLE_TIME_US * `ISC_CLK_MHZ
) (
	input  wire logic         clk,          // system clock
	input  wire logic         rst,          // synchronous reset, high
	input  wire logic [15:0]  regAddr,      // register address
	input  wire logic [3:0]   regWdata,     // write data
	input  wire logic         regWr,        // write strobe
	input  wire logic         regRd,        // read strobe
	output logic      [3:0]   regRdata,     // read data, cycle after regRd
	input  wire isc_events_t  events,       // peripheral events
	input  wire logic         wdNmiEv,      // watchdog timeout pulse
	input  wire isc_cpu_cmd_t cpuCmd,       // cpu strobes
	output logic              irqReq,       // maskable request level
	output logic              nmiReq,       // watchdog request level
	output logic      [15:0]  irqVector,    // vector of highest pending source
	output logic              intEnable,    // global interrupt enable flag
	output logic              cpuRun,       // cpu may execute
	output logic              hsOscEnable,  // high_speed_oscillator on
	output logic              periphClkEn   // low-speed clock to divider and peripherals
);
	localparam int NGRP = 5;  // ptimer, serial, port, clock timer, stopwatch

	// ------------------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------------------
	function automatic logic [15:0] flagOfs(input int g);
		case (g)
			0:       flagOfs = `ISC_OFS_PTIMER_FLAGS;
			1:       flagOfs = `ISC_OFS_SERIAL_FLAGS;
			2:       flagOfs = `ISC_OFS_PORT_FLAGS;
			3:       flagOfs = `ISC_OFS_CLKTMR_FLAGS;
			default: flagOfs = `ISC_OFS_STOPW_FLAGS;
		endcase
	endfunction : flagOfs

	function automatic logic [15:0] maskOfs(input int g);
		case (g)
			0:       maskOfs = `ISC_OFS_PTIMER_MASK;
			1:       maskOfs = `ISC_OFS_SERIAL_MASK;
			2:       maskOfs = `ISC_OFS_PORT_MASK;
			3:       maskOfs = `ISC_OFS_CLKTMR_MASK;
			default: maskOfs = `ISC_OFS_STOPW_MASK;
		endcase
	endfunction : maskOfs

	function automatic logic [3:0] grpBits(input int g);
		case (g)
			0:       grpBits = `ISC_BITS_PTIMER;
			1:       grpBits = `ISC_BITS_SERIAL;
			2:       grpBits = `ISC_BITS_PORT;
			3:       grpBits = `ISC_BITS_CLKTMR;
			default: grpBits = `ISC_BITS_STOPW;
		endcase
	endfunction : grpBits

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	logic [3:0]  flags_ff [NGRP];
	logic [3:0]  masks_ff [NGRP];
	logic [3:0]  clkLvlPrev_ff;
	logic        ieFlag_ff;
	logic        nmiPend_ff;
	logic        spReady_ff;
	logic [1:0]  spHalf_ff;
	isc_state_t  state_ff;
	isc_state_t  nxt_state;
	logic [3:0]  grpEv [NGRP];
	logic [NGRP-1:0] grpPend;
	logic        maskable;
	logic        reqNow;
	logic        portWake;
	logic        settleDone;
	logic [15:0] nxt_vector;

	// ------------------------------------------------------------------------
	// event mapping into flag positions
	// ------------------------------------------------------------------------
	always_comb begin
		grpEv[0] = {2'b00, events.ptimerZero};
		grpEv[1] = {1'b0, events.serialEv};
		grpEv[2] = events.portLineEv;
		grpEv[3] = clkLvlPrev_ff & ~events.clkTmrLvl;
		grpEv[4] = {2'b00, events.stopwEv};
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			clkLvlPrev_ff <= 4'h0;
		end else begin
			clkLvlPrev_ff <= events.clkTmrLvl;
		end
	end

	// ------------------------------------------------------------------------
	// factor flags: set wins over write-one-clear
	// ------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		for (int g = 0; g < NGRP; g++) begin
			if (rst) begin
				flags_ff[g] <= `ISC_FLAG_RESET;
			end else begin
				if (regWr && regAddr == flagOfs(g)) begin
					flags_ff[g] <= ((flags_ff[g] & ~regWdata) | grpEv[g]) & grpBits(g);
				end else begin
					flags_ff[g] <= (flags_ff[g] | grpEv[g]) & grpBits(g);
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// mask registers, same bit as flag, FFE page
	// ------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		for (int g = 0; g < NGRP; g++) begin
			if (rst) begin
				masks_ff[g] <= `ISC_MASK_RESET;
			end else if (regWr && regAddr == maskOfs(g)) begin
				masks_ff[g] <= regWdata & grpBits(g);
			end
		end
	end

	// ------------------------------------------------------------------------
	// read port; unmapped addresses and unused bits read zero
	// ------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			regRdata <= 4'h0;
		end else begin
			regRdata <= 4'h0;
			if (regRd) begin
				for (int g = 0; g < NGRP; g++) begin
					if (regAddr == flagOfs(g)) regRdata <= flags_ff[g];
					if (regAddr == maskOfs(g)) regRdata <= masks_ff[g];
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// stack pointer pairing gate
	// ------------------------------------------------------------------------
	// a lone write closes the gate until its partner arrives, so a half-set
	// stack never takes an interrupt
	always_ff @(posedge clk) begin
		if (rst) begin
			spReady_ff <= 1'b0;
			spHalf_ff  <= 2'b00;
		end else if (cpuCmd.sp1Write || cpuCmd.sp2Write) begin
			if ((spHalf_ff | {cpuCmd.sp2Write, cpuCmd.sp1Write}) == 2'b11) begin
				spReady_ff <= 1'b1;
				spHalf_ff  <= 2'b00;
			end else begin
				spReady_ff <= 1'b0;
				spHalf_ff  <= spHalf_ff | {cpuCmd.sp2Write, cpuCmd.sp1Write};
			end
		end
	end

	// ------------------------------------------------------------------------
	// global enable flag
	// ------------------------------------------------------------------------
	// accept has priority over an enable in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			ieFlag_ff <= 1'b0;
		end else if (cpuCmd.irqAck) begin
			ieFlag_ff <= 1'b0;
		end else if (cpuCmd.diSet) begin
			ieFlag_ff <= 1'b0;
		end else if (cpuCmd.eiSet || cpuCmd.retiExec) begin
			ieFlag_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// watchdog pending: no flag register, no mask
	// ------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			nmiPend_ff <= 1'b0;
		end else if (wdNmiEv) begin
			nmiPend_ff <= 1'b1;
		end else if (cpuCmd.irqAck && nmiReq) begin
			nmiPend_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// request gating and priority
	// ------------------------------------------------------------------------
	always_comb begin
		for (int g = 0; g < NGRP; g++) begin
			grpPend[g] = |(flags_ff[g] & masks_ff[g]);
		end
		maskable   = |grpPend;
		reqNow     = spReady_ff && (nmiPend_ff || (maskable && ieFlag_ff));
		nxt_vector = `ISC_VEC_BASE;
		if (!nmiPend_ff) begin
			for (int g = NGRP - 1; g >= 0; g--) begin
				if (grpPend[g]) nxt_vector = `ISC_VEC_BASE + 16'((g + 1) * 2);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irqReq    <= 1'b0;
			nmiReq    <= 1'b0;
			irqVector <= `ISC_VEC_BASE;
			intEnable <= 1'b0;
		end else begin
			irqReq    <= spReady_ff && ieFlag_ff && maskable;
			nmiReq    <= spReady_ff && nmiPend_ff;
			irqVector <= nxt_vector;
			intEnable <= ieFlag_ff;
		end
	end

	// ------------------------------------------------------------------------
	// halt / sleep sequencer
	// ------------------------------------------------------------------------
	assign portWake = |events.portLineEv;

	always_comb begin
		case (state_ff)
			ISC_RUN: begin
				if (cpuCmd.sleepExec)     nxt_state = ISC_SLEEP;
				else if (cpuCmd.haltExec) nxt_state = ISC_HALT;
				else                      nxt_state = ISC_RUN;
			end
			ISC_HALT:   nxt_state = reqNow ? ISC_RUN : ISC_HALT;
			ISC_SLEEP:  nxt_state = portWake ? ISC_SETTLE : ISC_SLEEP;
			ISC_SETTLE: nxt_state = settleDone ? ISC_RUN : ISC_SETTLE;
			default:    nxt_state = ISC_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= ISC_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// clock outputs follow the next state so they change with the state
	always_ff @(posedge clk) begin
		if (rst) begin
			cpuRun      <= 1'b1;
			hsOscEnable <= 1'b1;
			periphClkEn <= 1'b1;
		end else begin
			cpuRun      <= (nxt_state == ISC_RUN);
			hsOscEnable <= (nxt_state != ISC_SLEEP);
			periphClkEn <= (nxt_state != ISC_SLEEP);
		end
	end

	// settle wait starts when the port factor ends sleep
	isc_osc_settle #(
		.SETTLE_CYCLES (SETTLE_CYCLES)
	) u_settle (
		.clk   (clk),
		.rst   (rst),
		.start (state_ff == ISC_SLEEP && portWake),
		.done  (settleDone)
	);

	// ------------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence sleepEntered;
		state_ff == ISC_RUN && cpuCmd.sleepExec;
	endsequence

	sequence portWoke;
		state_ff == ISC_SLEEP && portWake;
	endsequence

	irq_gating_a: assert property (
		irqReq |-> $past(ieFlag_ff) && $past(maskable) && $past(spReady_ff))
		else $error("maskable request without flag, mask and enable");

	ack_clears_ie_a: assert property (
		cpuCmd.irqAck |=> !ieFlag_ff ##1 !irqReq)
		else $error("accept did not clear global enable");

	nmi_unmasked_a: assert property (
		wdNmiEv && spReady_ff && !cpuCmd.sp1Write && !cpuCmd.sp2Write |-> ##2 nmiReq)
		else $error("watchdog request not raised");

	sp_block_a: assert property (
		!spReady_ff |=> !irqReq && !nmiReq)
		else $error("request passed while stack pointers unpaired");

	flag_w1c_a: assert property (
		regWr && regAddr == `ISC_OFS_PTIMER_FLAGS && regWdata[0] && !events.ptimerZero[0]
		|=> !flags_ff[0][0])
		else $error("write one did not clear flag");

	set_wins_a: assert property (
		events.serialEv[1] |=> flags_ff[1][1])
		else $error("set event lost");

	sleep_hold_a: assert property (
		state_ff == ISC_SLEEP && !portWake |=> state_ff == ISC_SLEEP)
		else $error("sleep left without port factor");

	sleep_clocks_a: assert property (
		sleepEntered |=> !cpuRun && !hsOscEnable && !periphClkEn)
		else $error("sleep did not stop clocks");

	wake_settle_a: assert property (
		portWoke |=> state_ff == ISC_SETTLE ##1 !cpuRun)
		else $error("cpu resumed before settling");

	halt_wake_a: assert property (
		state_ff == ISC_HALT && reqNow |=> cpuRun)
		else $error("halt not left on request");

endmodule : isc_ctrl

// >>> bench/isc_cpu_model.sv
// Purpose: behavioural cpu core that answers the controller's requests
// Assumes: requests are levels; ackDelay cycles of patience before accepting
// Notes:   after an accept it waits out the request's fall before looking again
`timescale 1ns/1ps
module isc_cpu_model
	import isc_pkg::*;
(
	input  wire logic         clk,        // system clock
	input  wire logic         rst,        // synchronous reset, high
	input  wire logic         irqReq,     // maskable request level
	input  wire logic         nmiReq,     // watchdog request level
	input  wire logic [15:0]  irqVector,  // vector offered by controller
	input  wire logic         ackEnable,  // bench lets the core accept
	input  wire logic [3:0]   ackDelay,   // cycles to wait before accepting
	input  wire isc_cpu_cmd_t cmdIn,      // instruction strobes from bench
	output isc_cpu_cmd_t      cpuCmd,     // strobes to controller
	output logic      [15:0]  lastVec_ff  // vector taken at last accept
);
	logic [3:0] waitCnt_ff;
	logic [1:0] holdOff_ff;
	logic       ackPulse_ff;
	logic       ackNow;

	// accept only a standing request; the hold-off covers the two-cycle fall
	assign ackNow = ackEnable && (irqReq || nmiReq) && holdOff_ff == 2'h0
		&& waitCnt_ff >= ackDelay && !ackPulse_ff;

	// -------------------------------------------------------------------------
	// accept sequence
	// -------------------------------------------------------------------------
	// ack is a registered pulse so it changes just after an edge
	always_ff @(posedge clk) begin
		if (rst) begin
			waitCnt_ff  <= 4'h0;
			holdOff_ff  <= 2'h0;
			ackPulse_ff <= 1'b0;
			lastVec_ff  <= 16'h0000;
		end else begin
			ackPulse_ff <= ackNow;
			if (ackNow) begin
				lastVec_ff <= irqVector;
				holdOff_ff <= 2'h3;
			end else if (holdOff_ff != 2'h0) begin
				holdOff_ff <= holdOff_ff - 2'h1;
			end
			if (!(irqReq || nmiReq) || ackNow) begin
				waitCnt_ff <= 4'h0;
			end else if (waitCnt_ff != 4'hF) begin
				waitCnt_ff <= waitCnt_ff + 4'h1;
			end
		end
	end

	// bench strobes pass through except irqAck, which the model drives; the bench writes the stack pointers one at a time
	always_comb begin
		cpuCmd        = cmdIn;
		cpuCmd.irqAck = ackPulse_ff;
	end
endmodule : isc_cpu_model

// >>> bench/isc_ctrl_tb.sv
// Purpose: self-checking bench of the interrupt and standby controller
// Assumes: SETTLE_CYCLES shortened to 8; core model answers requests
// Notes:   bus drives on rising edges, samples 1 ns after an edge
`timescale 1ns/1ps
`include "isc_params.svh"
module isc_ctrl_tb
	import isc_pkg::*;
;
	logic         clk, rst, regWr, regRd, wdNmiEv, ackEnable;
	logic [15:0]  regAddr, irqVector, lastVec;
	logic [3:0]   regWdata, regRdata;
	isc_events_t  events;
	isc_cpu_cmd_t cmdIn, cpuCmd;
	logic         irqReq, nmiReq, intEnable, cpuRun, hsOscEnable, periphClkEn;
	int           errors, n_compared, i;

	localparam logic [15:0] FLG [5] = '{`ISC_OFS_PTIMER_FLAGS, `ISC_OFS_SERIAL_FLAGS,
		`ISC_OFS_PORT_FLAGS, `ISC_OFS_CLKTMR_FLAGS, `ISC_OFS_STOPW_FLAGS};
	localparam logic [15:0] MSK [5] = '{`ISC_OFS_PTIMER_MASK, `ISC_OFS_SERIAL_MASK,
		`ISC_OFS_PORT_MASK, `ISC_OFS_CLKTMR_MASK, `ISC_OFS_STOPW_MASK};
	localparam logic [3:0]  BITS [5] = '{4'h3, 4'h7, 4'hF, 4'hF, 4'h3};
	localparam logic [15:0] VEC [5] = '{16'h0102, 16'h0104, 16'h0106, 16'h0108, 16'h010A};

	isc_ctrl #(.SETTLE_CYCLES(8)) DUT (.clk(clk), .rst(rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.events(events), .wdNmiEv(wdNmiEv), .cpuCmd(cpuCmd), .irqReq(irqReq),
		.nmiReq(nmiReq), .irqVector(irqVector), .intEnable(intEnable), .cpuRun(cpuRun),
		.hsOscEnable(hsOscEnable), .periphClkEn(periphClkEn));

	isc_cpu_model cpu (.clk(clk), .rst(rst), .irqReq(irqReq), .nmiReq(nmiReq),
		.irqVector(irqVector), .ackEnable(ackEnable), .ackDelay(4'h2), .cmdIn(cmdIn),
		.cpuCmd(cpuCmd), .lastVec_ff(lastVec));

	// -------------------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------------------
	task final_report;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task wr(input logic [15:0] a, input logic [3:0] d);
		@(posedge clk);
		regWr    <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge clk);
		regWr    <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task rd(input logic [15:0] a, input logic [3:0] exp);
		@(posedge clk);
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd   <= 1'b0;
		#1;
		chk("regRdata", {12'h000, exp}, {12'h000, regRdata});
	endtask : rd

	task ev(input isc_events_t e, input logic wd);
		@(posedge clk);
		events  <= e;
		wdNmiEv <= wd;
		@(posedge clk);
		events  <= '0;
		wdNmiEv <= 1'b0;
	endtask : ev

	task cmd(input isc_cpu_cmd_t c);
		@(posedge clk);
		cmdIn <= c;
		@(posedge clk);
		cmdIn <= '0;
	endtask : cmd

	function automatic logic sel(input int w);
		case (w)
			0: sel = irqReq;
			1: sel = nmiReq;
			2: sel = cpuRun;
			default: sel = hsOscEnable;
		endcase
	endfunction : sel

	// bounded wait; running out counts as a mismatch and ends the run
	task waitfor(input int w, input logic v, input string nm);
		// step off the edge so the value launched by it has settled
		#1;
		for (int k = 0; k < 40 && sel(w) !== v; k++) begin
			@(posedge clk);
			#1;
		end
		chk(nm, {15'h0000, v}, {15'h0000, sel(w)});
		if (sel(w) !== v) final_report();
	endtask : waitfor

	task holds(input int w, input logic v, input int n, input string nm);
		repeat (n) begin
			@(posedge clk);
			#1;
			chk(nm, {15'h0000, v}, {15'h0000, sel(w)});
		end
	endtask : holds

	// -------------------------------------------------------------------------
	// clock and sequence
	// -------------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		rst = 1'b1; regWr = 1'b0; regRd = 1'b0; regAddr = '0; regWdata = '0;
		events = '0; wdNmiEv = 1'b0; cmdIn = '0; ackEnable = 1'b0;
		errors = 0; n_compared = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("cpuRun", 16'h0001, {15'h0000, cpuRun});
		for (i = 0; i < 5; i++) begin
			rd(FLG[i], 4'h0);
			rd(MSK[i], 4'h0);
			wr(MSK[i], 4'hF);
			rd(MSK[i], BITS[i]);
		end
		wr(16'hFFE0, 4'hF);
		rd(16'hFFE0, 4'h0);
		ev({2'h3, 3'h7, 4'hF, 4'hF, 2'h3}, 1'b0);
		for (i = 0; i < 5; i++) rd(FLG[i], BITS[i]);
		cmd(8'h40);
		holds(0, 1'b0, 4, "irqReq closed");
		cmd(8'h02);
		holds(0, 1'b0, 4, "irqReq lone sp");
		cmd(8'h01);
		waitfor(0, 1'b1, "irqReq open");
		wr(FLG[0], 4'h0);
		rd(FLG[0], 4'h3);
		wr(FLG[0], 4'h1);
		rd(FLG[0], 4'h2);
		// clearing groups in priority order walks the vector up, 0102 to 010A
		for (i = 0; i < 5; i++) begin
			repeat (3) @(posedge clk);
			#1;
			chk("irqVector", VEC[i], irqVector);
			wr(FLG[i], 4'hF);
		end
		waitfor(0, 1'b0, "irqReq none");
		wr(MSK[4], 4'h0);
		@(posedge clk);
		events   <= {2'h0, 3'h0, 4'h0, 4'h0, 2'h1};
		regWr    <= 1'b1;
		regAddr  <= FLG[4];
		regWdata <= 4'h1;
		@(posedge clk);
		events   <= '0;
		regWr    <= 1'b0;
		rd(FLG[4], 4'h1);
		holds(0, 1'b0, 3, "irqReq masked");
		wr(MSK[4], 4'hF);
		waitfor(0, 1'b1, "irqReq unmasked");
		@(posedge clk);
		ackEnable <= 1'b1;
		waitfor(0, 1'b0, "irqReq after ack");
		chk("intEnable", 16'h0000, {15'h0000, intEnable});
		chk("lastVec", 16'h010A, lastVec);
		cmd(8'h40);
		waitfor(0, 1'b1, "irqReq reenabled");
		waitfor(0, 1'b0, "irqReq acked");
		// a return with the flag still set asks again
		cmd(8'h10);
		waitfor(0, 1'b1, "irqReq on return");
		waitfor(0, 1'b0, "irqReq acked again");
		wr(FLG[4], 4'hF);
		cmd(8'h02);
		ev('0, 1'b1);
		holds(1, 1'b0, 4, "nmiReq lone sp");
		cmd(8'h01);
		waitfor(1, 1'b1, "nmiReq");
		chk("irqVector", 16'h0100, irqVector);
		waitfor(1, 1'b0, "nmiReq acked");
		cmd(8'h08);
		holds(2, 1'b0, 2, "cpuRun halt");
		ev('0, 1'b1);
		waitfor(2, 1'b1, "cpuRun wake");
		waitfor(1, 1'b0, "nmiReq halt");
		// no accepts while asleep: the core is stopped
		@(posedge clk);
		ackEnable <= 1'b0;
		cmd(8'h40);
		cmd(8'h20);
		@(posedge clk);
		#1;
		chk("intEnable di", 16'h0000, {15'h0000, intEnable});
		// software prepares the wake line: enable set, port mask already set
		cmd(8'h40);
		cmd(8'h04);
		holds(3, 1'b0, 2, "hsOscEnable sleep");
		chk("periphClkEn", 16'h0000, {15'h0000, periphClkEn});
		ev({2'h3, 3'h7, 4'h0, 4'hF, 2'h3}, 1'b1);
		holds(2, 1'b0, 6, "cpuRun sleep");
		chk("hsOscEnable", 16'h0000, {15'h0000, hsOscEnable});
		ev({2'h0, 3'h0, 4'h1, 4'h0, 2'h0}, 1'b0);
		waitfor(3, 1'b1, "hsOscEnable wake");
		chk("cpuRun settle", 16'h0000, {15'h0000, cpuRun});
		waitfor(2, 1'b1, "cpuRun resumed");
		final_report();
	end
endmodule : isc_ctrl_tb
